// *** bench/ccr_host_model.sv ***
`timescale 1ns/1ps
module ccr_host_model (
    input wire logic clk,
    input wire logic waitrequest,
    input wire logic [31:0] readdata,
    output logic [5:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable
);
    int timeouts = 0;
    initial begin
        address = 6'h3f;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'hffffffff;
        byteenable = 4'h0;
    end
    task automatic access(input logic rd, input logic [5:0] a, input logic [7:0] d,
                          input logic [3:0] be, output logic [31:0] q);
        int n;
        @(posedge clk);
        address <= a;
        read <= rd;
        write <= !rd;
        writedata <= {24'h0, d};
        byteenable <= be;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest && n < 50);
        if (waitrequest) timeouts++;
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        // released address and data show garbage, never the last value
        address <= ~a;
        writedata <= ~{24'h0, d};
    endtask : access
    // no further command until the lock flag is seen or 40 state reads have passed
    task automatic wait_lock;
        logic [31:0] q;
        int n;
        n = 0;
        q = 32'h0;
        while (!q[0] && n < 40) begin
            access(1'b1, 6'h28, 8'h00, 4'hf, q);
            n++;
        end
        if (!q[0]) timeouts++;
    endtask : wait_lock
endmodule : ccr_host_model

// *** bench/ccr_top_asserts.sv ***
`timescale 1ns/1ps
module ccr_top_asserts #(
    parameter int LOCK_CYCLES = 20
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    input wire logic AVS_WAITREQUEST,
    input wire logic IRQ,
    input wire logic PCM_LINE_OE,
    input wire logic LOCAL_LOOP,
    input wire logic PCM_CLOCK_MASTER,
    input wire logic OSC_16M_SEL,
    input wire logic PARALLEL_MODE,
    input wire logic PLL_LOCKED,
    input wire logic [3:0] DATA_RATE_RANGE,
    input wire logic [7:0] PROG_CLK_CLOCK_MODE,
    input wire logic [7:0] PROG_CLK_ACTIVE_LOW
);
    logic c2, c1;
    logic [7:0] c;
    logic [31:0] lk_cnt;
    // completion edge of a write to a command register
    assign c = AVS_WRITEDATA[7:0];
    assign c2 = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS[5:2] == 4'h0;
    assign c1 = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0] && AVS_ADDRESS[5:2] == 4'h1;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) lk_cnt <= 32'h0;
        else if (c2 && (c == 8'h01 || c == 8'h11)) lk_cnt <= 32'h0;
        else lk_cnt <= lk_cnt + 32'h1;
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_B);
////////////////////////////////////////////////////////////////////////////////
    chk_read_one_wait: assert property (
        $rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("read wait");
    chk_standby_on: assert property (
        c2 && c == 8'h14 |-> ##2 PCM_LINE_OE) else $error("standby enable");
    chk_standby_off: assert property (
        c2 && c == 8'h04 |-> ##2 !PCM_LINE_OE) else $error("standby disable");
    chk_lines_float: assert property (
        $rose(PCM_LINE_OE) |-> $past(c2 && c == 8'h14, 2)) else $error("lines enabled");
    chk_loop_set: assert property (
        c2 && c[3:0] == 4'h5 && c[7:4] <= 4'h1 |-> ##2 LOCAL_LOOP == $past(c[4], 2))
        else $error("loop");
    chk_frame_pol: assert property (
        c2 && c[3:0] == 4'h6 |-> ##2 PROG_CLK_ACTIVE_LOW[$past(c[6:4], 2)] == $past(c[7], 2))
        else $error("frame polarity");
    chk_clock_line: assert property (
        c2 && c[3:0] == 4'h7 && !c[7] |-> ##2 PROG_CLK_CLOCK_MODE[$past(c[6:4], 2)])
        else $error("clock line");
    chk_range_store: assert property (
        c2 && c[3:0] == 4'h8 && c[7:4] != 4'h7 && c[7:4] <= 4'ha
        |-> ##2 DATA_RATE_RANGE == $past(c[7:4], 2)) else $error("range");
    chk_freq_sel: assert property (
        c2 && c[3:0] == 4'h1 && c[7:4] <= 4'h1 |-> ##2 !PLL_LOCKED
        && OSC_16M_SEL == $past(c[4], 2)) else $error("frequency select");
    chk_lock_time: assert property (
        $rose(PLL_LOCKED) |-> lk_cnt >= LOCK_CYCLES && lk_cnt <= LOCK_CYCLES + 2)
        else $error("lock time");
    chk_master_sel: assert property (
        c1 && c[3:0] == 4'h2 |-> ##2 PCM_CLOCK_MASTER == $past(c[4], 2))
        else $error("clock master");
    chk_parallel_set: assert property (
        c2 && c[3:0] == 4'h2 && c[7:4] <= 4'h1 |-> ##2 PARALLEL_MODE == $past(c[4], 2))
        else $error("parallel mode");
    cov_standby: cover property (c2 && c == 8'h14);
    cov_irq: cover property ($rose(IRQ));
    cov_lock: cover property ($rose(PLL_LOCKED));
endmodule : ccr_top_asserts
bind ccr_top ccr_top_asserts #(.LOCK_CYCLES(LOCK_CYCLES)) i_chk (.*);

// *** bench/ccr_top_tb.sv ***
`timescale 1ns/1ps
module ccr_top_tb;
    localparam int LOCK = 20;
    logic CLK, RST_B, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IRQ, PCM_LINE_OE, LOCAL_LOOP;
    logic PCM_CLOCK_MASTER, OSC_16M_SEL, PARALLEL_MODE, PLL_LOCKED;
    logic [5:0] AVS_ADDRESS;
    logic [31:0] AVS_WRITEDATA, AVS_READDATA;
    logic [3:0] AVS_BYTEENABLE, DATA_RATE_RANGE, rng;
    logic [7:0] PROG_CLK_CLOCK_MODE, PROG_CLK_ACTIVE_LOW;
    logic [31:0] q;
    int errors = 0;
    int samples_checked = 0;
    ccr_top #(.LOCK_CYCLES(LOCK)) i_dut (.*);
    ccr_host_model i_host (.clk(CLK), .waitrequest(AVS_WAITREQUEST), .readdata(AVS_READDATA),
        .address(AVS_ADDRESS), .read(AVS_READ), .write(AVS_WRITE), .writedata(AVS_WRITEDATA),
        .byteenable(AVS_BYTEENABLE));
    initial begin
        CLK = 1'b0;
        forever #4 CLK = ~CLK;
    end
////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic bus(input logic rd, input logic [5:0] a, input logic [7:0] d,
                       input logic [3:0] be);
        i_host.access(rd, a, d, be, q);
        if (i_host.timeouts != 0) begin
            errors++;
            results();
        end
    endtask : bus
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        bus(1'b0, a, d, 4'h1);
        repeat (3) @(posedge CLK);
    endtask : wr
    task automatic rd(input string what, input logic [5:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
        bus(1'b1, a, 8'h00, 4'hf);
        cmp(what, exp, q & m);
    endtask : rd
////////////////////////////////////////////////////////////////////////////////
    initial begin
        RST_B = 1'b0;
        repeat (10) @(posedge CLK);
        RST_B <= 1'b1;
        @(posedge CLK);
        cmp("line_oe", 0, PCM_LINE_OE);
        cmp("range", 0, DATA_RATE_RANGE);
        rd("unmapped", 6'h3c, 32'hffffffff, 0);
        wr(6'h24, 8'h03);
        wr(6'h00, 8'h11);
        cmp("osc16", 1, OSC_16M_SEL);
        cmp("lock_drop", 0, PLL_LOCKED);
        i_host.wait_lock();
        cmp("lock_irq", 1, IRQ);
        rd("status", 6'h20, 32'h3, 32'h2);
        wr(6'h20, 8'h03);
        cmp("irq_clear", 0, IRQ);
        wr(6'h00, 8'h01);
        cmp("osc32", 0, OSC_16M_SEL);
        i_host.wait_lock();
        wr(6'h20, 8'h03);
        bus(1'b0, 6'h00, 8'h14, 4'h0);
        repeat (3) @(posedge CLK);
        cmp("be_ignored", 0, PCM_LINE_OE);
        wr(6'h00, 8'h14);
        cmp("line_on", 1, PCM_LINE_OE);
        wr(6'h00, 8'h15);
        cmp("loop_on", 1, LOCAL_LOOP);
        wr(6'h00, 8'hd9);
        cmp("result_irq", 1, IRQ);
        rd("rd_standby", 6'h18, 32'hff, 1);
        wr(6'h20, 8'h01);
        wr(6'h00, 8'he9);
        rd("rd_loop", 6'h18, 32'hff, 1);
        wr(6'h00, 8'h05);
        cmp("loop_off", 0, LOCAL_LOOP);
        wr(6'h00, 8'he9);
        rd("rd_noloop", 6'h18, 32'hff, 0);
        wr(6'h00, 8'h04);
        cmp("line_off", 0, PCM_LINE_OE);
        wr(6'h10, 8'h12);
        wr(6'h14, 8'hc0);
        rd("gin2", 6'h14, 32'hff, 32'hc0);
        wr(6'h00, 8'h96);
        wr(6'h00, 8'h26);
        cmp("frame_pol", 8'h02, PROG_CLK_ACTIVE_LOW);
        wr(6'h00, 8'h37);
        cmp("clock_lines", 8'h08, PROG_CLK_CLOCK_MODE);
        wr(6'h00, 8'h1a);
        rd("clkrb_line1", 6'h1c, 32'h300, 32'h100);
        rd("clkrb_kept", 6'h1c, 32'h300, 32'h100);
        wr(6'h00, 8'h3a);
        rd("clkrb_line3", 6'h1c, 32'h300, 32'h200);
        rng = 4'h0;
        for (int i = 0; i < 16; i++) begin
            wr(6'h00, {i[3:0], 4'h8});
            if (i != 7 && i <= 10) rng = i[3:0];
            cmp("range_code", rng, DATA_RATE_RANGE);
        end
        wr(6'h00, 8'hf9);
        rd("rd_range", 6'h18, 32'hff, rng);
        wr(6'h20, 8'h01);
        wr(6'h24, 8'h00);
        wr(6'h00, 8'hf9);
        cmp("masked", 0, IRQ);
        rd("status_set", 6'h20, 32'h1, 32'h1);
        wr(6'h24, 8'h01);
        cmp("unmasked", 1, IRQ);
        wr(6'h20, 8'h01);
        wr(6'h08, 8'h08);
        wr(6'h0c, 8'h01);
        wr(6'h04, 8'hdb);
        wr(6'h00, 8'h0b);
        rd("rate_in", 6'h18, 32'hff, 1);
        wr(6'h00, 8'h1b);
        rd("rate_out", 6'h18, 32'hff, 1);
        wr(6'h10, 8'h08);
        wr(6'h04, 8'h0f);
        wr(6'h00, 8'h0d);
        rd("shift_in", 6'h18, 32'hff, 8'h08);
        wr(6'h10, 8'h01);
        wr(6'h04, 8'h2f);
        wr(6'h00, 8'h1d);
        rd("shift_out", 6'h18, 32'hff, 8'h01);
        wr(6'h10, 8'h15);
        wr(6'h04, 8'h12);
        cmp("master", 1, PCM_CLOCK_MASTER);
        wr(6'h00, 8'h09);
        rd("rd_master", 6'h18, 32'hff, 1);
        wr(6'h00, 8'h19);
        rd("rd_pll_ref", 6'h18, 32'hff, 5);
        wr(6'h00, 8'h59);
        rd("rd_clk_sel", 6'h18, 32'hff, 1);
        wr(6'h00, 8'h99);
        rd("rd_align", 6'h18, 32'hff, 1);
        wr(6'h00, 8'h12);
        cmp("parallel", 1, PARALLEL_MODE);
        wr(6'h00, 8'hb9);
        rd("rd_parallel", 6'h18, 32'hff, 1);
        wr(6'h00, 8'h53);
        wr(6'h00, 8'h33);
        wr(6'h00, 8'hc9);
        rd("rd_irq_pin", 6'h18, 32'hff, 5);
        wr(6'h04, 8'h02);
        cmp("slave", 0, PCM_CLOCK_MASTER);
        rd("cmd_reads_zero", 6'h00, 32'hffffffff, 0);
        results();
    end
    initial begin
        #400000;
        errors++;
        results();
    end
endmodule : ccr_top_tb

// *** rtl/ccr_lock_timer.sv ***
`timescale 1ns/1ps
module ccr_lock_timer #(
    parameter int LOCK_CYCLES = 93750
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic start,
    output logic locked,
    output logic lock_event
);
    ccr_pkg::ccr_lock_s s_reg;
    ccr_pkg::ccr_lock_s s_next;

    // a new frequency restarts the lock wait and drops the flag
    always_comb begin
        s_next = s_reg;
        if (start) begin
            s_next.busy = 1'b1;
            s_next.locked = 1'b0;
            s_next.count = 24'(LOCK_CYCLES - 1);
        end else if (s_reg.busy) begin
            if (s_reg.count == 24'h0) begin
                s_next.busy = 1'b0;
                s_next.locked = 1'b1;
            end else begin
                s_next.count = s_reg.count - 24'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign locked = s_reg.locked;
    assign lock_event = s_reg.busy && !start && s_reg.count == 24'h0;
endmodule : ccr_lock_timer

// *** rtl/ccr_pkg.sv ***
package ccr_pkg;
    typedef enum logic [1:0] {
        CCR_IDLE = 2'b00,
        CCR_DECODE = 2'b01,
        CCR_STORE = 2'b11
    } ccr_phase_e;

    typedef struct packed {
        logic [23:0] count;
        logic busy;
        logic locked;
    } ccr_lock_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        ccr_phase_e phase;
        logic cmd_first;
        logic [7:0] cmd;
        logic rb;
        logic [7:0] src;
        logic [7:0] dst;
        logic [7:0] gin1;
        logic [7:0] gin2;
        logic [7:0] result;
        logic [9:0] clkrb;
        logic [1:0] status;
        logic [1:0] mask;
        logic standby;
        logic loop;
        logic master;
        logic osc16;
        logic parallel;
        logic [3:0] irq_cfg;
        logic [3:0] range;
        logic [3:0] pll_ref;
        logic [3:0] clk_sel;
        logic phase_align;
        logic [7:0] gp_clock;
        logic [7:0] gp_low;
        logic [7:0][7:0] gp_a;
        logic [7:0][7:0] gp_b;
        logic [15:0][1:0] in_rate;
        logic [15:0][1:0] out_rate;
        logic [15:0][7:0] in_shift;
        logic [7:0] out_shift;
    } ccr_top_s;
endpackage : ccr_pkg

// *** rtl/ccr_regs.svh ***
// Functional notes
// - low nibble command, high nibble parameter
// - code 4 disables or enables local bus
// - code 5 removes or enables local loop
// - code 6 sets frame polarity, line, shape
// - code 7 makes clock line a clock
// - code 8 stores data-rate range code
// - code 9 reads one configuration item
// - code A returns clock line configuration
// - clock readback raises the result interrupt when unmasked, persists; code A sets the result status bit
// - line and shift readbacks fill result
// - code D returns input or output shift
// - lock flag about 750 us after frequency
// - master generates clocks, slave takes them
// - frequency parameter 0 32.768, 1 16.384
// - data lines float until standby enables
`ifndef CCR_REGS_SVH
`define CCR_REGS_SVH
////////////////////////////////////////////////////////////////////////////////
`define CCR_OFS_SECOND_CMD 4'h0
`define CCR_OFS_FIRST_CMD 4'h1
`define CCR_OFS_SRC 4'h2
`define CCR_OFS_DST 4'h3
`define CCR_OFS_GIN1 4'h4
`define CCR_OFS_GIN2 4'h5
`define CCR_OFS_RESULT 4'h6
`define CCR_OFS_CLKRB 4'h7
`define CCR_OFS_STATUS 4'h8
`define CCR_OFS_MASK 4'h9
`define CCR_OFS_STATE 4'ha
////////////////////////////////////////////////////////////////////////////////
`define CCR_ST_RESULT 0
`define CCR_ST_LOCK 1
`define CCR_RST_RATE 2'h0
`define CCR_RST_RANGE 4'h0
`define CCR_RST_BYTE 8'h00
////////////////////////////////////////////////////////////////////////////////
`define CCR_C2_FREQ 4'h1
`define CCR_C2_PAR 4'h2
`define CCR_C2_IRQ 4'h3
`define CCR_C2_STBY 4'h4
`define CCR_C2_LOOP 4'h5
`define CCR_C2_FRAME 4'h6
`define CCR_C2_CLOCK 4'h7
`define CCR_C2_RANGE 4'h8
`define CCR_C2_RDCFG 4'h9
`define CCR_C2_RDCLK 4'ha
`define CCR_C2_RDLINE 4'hb
`define CCR_C2_RDSHIFT 4'hd
`define CCR_C1_IOSEL 4'h2
`define CCR_C1_RATE 4'hb
`define CCR_C1_SHIFT 4'hf
////////////////////////////////////////////////////////////////////////////////
`define CCR_LOCK_TIME_US 750
`define CCR_CLK_MHZ 125
`endif

// *** rtl/ccr_top.sv ***
// Our own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps
`include "ccr_regs.svh"
module ccr_top #(
    parameter int LOCK_CYCLES = `CCR_LOCK_TIME_US * `CCR_CLK_MHZ
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic [5:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [3:0] AVS_BYTEENABLE,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    output logic IRQ,
    output logic PCM_LINE_OE,
    output logic LOCAL_LOOP,
    output logic PCM_CLOCK_MASTER,
    output logic OSC_16M_SEL,
    output logic PARALLEL_MODE,
    output logic PLL_LOCKED,
    output logic [3:0] DATA_RATE_RANGE,
    output logic [7:0] PROG_CLK_CLOCK_MODE,
    output logic [7:0] PROG_CLK_ACTIVE_LOW
);
    ////////////////////////////////////////////////////////////////////////////
    generate
        if (LOCK_CYCLES < 1 || LOCK_CYCLES > 24'hffffff) begin : g_bad_lock
            $error("LOCK_CYCLES out of range");
        end
    endgenerate

    ccr_pkg::ccr_top_s s_reg;
    ccr_pkg::ccr_top_s s_next;
    logic req;
    logic cmd_addr;
    logic blocked;
    logic wr_go;
    logic [31:0] rd_mux;
    logic [3:0] code;
    logic [3:0] param;
    logic lock_start;
    logic lock_event;
    logic pll_locked;
    logic [1:0] set_ev;
    logic [1:0] clr_ev;
    logic [2:0] gp_line;
    logic [3:0] src_line;
    logic [3:0] dst_line;

    ////////////////////////////////////////////////////////////////////////////
    assign req = AVS_READ || AVS_WRITE;
    assign cmd_addr = AVS_ADDRESS[5:2] == `CCR_OFS_SECOND_CMD
        || AVS_ADDRESS[5:2] == `CCR_OFS_FIRST_CMD;
    // a command that arrives while one is still executing is held off
    assign blocked = AVS_WRITE && cmd_addr && s_reg.phase != ccr_pkg::CCR_IDLE;
    assign wr_go = AVS_WRITE && s_reg.ack && AVS_BYTEENABLE[0];
    assign code = s_reg.cmd[3:0];
    assign param = s_reg.cmd[7:4];
    assign gp_line = param[2:0];
    assign src_line = s_reg.src[3:0];
    assign dst_line = s_reg.dst[3:0];
    assign lock_start = s_reg.phase == ccr_pkg::CCR_DECODE && !s_reg.cmd_first
        && code == `CCR_C2_FREQ && param[3:1] == 3'h0;
    assign set_ev[`CCR_ST_RESULT] = s_reg.phase == ccr_pkg::CCR_STORE && s_reg.rb;
    assign set_ev[`CCR_ST_LOCK] = lock_event;
    assign clr_ev = (wr_go && AVS_ADDRESS[5:2] == `CCR_OFS_STATUS) ? AVS_WRITEDATA[1:0] : 2'h0;

    // lock wait restarts on every valid frequency command
    ccr_lock_timer #(
        .LOCK_CYCLES(LOCK_CYCLES)
    ) u_lock (
        .clk(CLK),
        .rst_b(RST_B),
        .start(lock_start),
        .locked(pll_locked),
        .lock_event(lock_event)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read mux; readback registers keep their value on read
    always_comb begin
        rd_mux = 32'h0;
        case (AVS_ADDRESS[5:2])
            `CCR_OFS_SRC: begin
                rd_mux[7:0] = s_reg.src;
            end
            `CCR_OFS_DST: begin
                rd_mux[7:0] = s_reg.dst;
            end
            `CCR_OFS_GIN1: begin
                rd_mux[7:0] = s_reg.gin1;
            end
            `CCR_OFS_GIN2: begin
                rd_mux[7:0] = s_reg.gin2;
            end
            `CCR_OFS_RESULT: begin
                rd_mux[7:0] = s_reg.result;
            end
            `CCR_OFS_CLKRB: begin
                rd_mux[9:0] = s_reg.clkrb;
            end
            `CCR_OFS_STATUS: begin
                rd_mux[1:0] = s_reg.status;
            end
            `CCR_OFS_MASK: begin
                rd_mux[1:0] = s_reg.mask;
            end
            `CCR_OFS_STATE: begin
                rd_mux[0] = pll_locked;
                rd_mux[1] = s_reg.phase != ccr_pkg::CCR_IDLE;
            end
            default: begin
                rd_mux = 32'h0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        s_next = s_reg;
        s_next.ack = req && !s_reg.ack && !blocked;
        if (req && !s_reg.ack) begin
            s_next.rdata = rd_mux;
        end
        // a new event wins over a clear in the same cycle
        s_next.status = (s_reg.status & ~clr_ev) | set_ev;

        if (wr_go) begin
            case (AVS_ADDRESS[5:2])
                `CCR_OFS_SECOND_CMD: begin
                    s_next.cmd = AVS_WRITEDATA[7:0];
                    s_next.cmd_first = 1'b0;
                    s_next.phase = ccr_pkg::CCR_DECODE;
                end
                `CCR_OFS_FIRST_CMD: begin
                    s_next.cmd = AVS_WRITEDATA[7:0];
                    s_next.cmd_first = 1'b1;
                    s_next.phase = ccr_pkg::CCR_DECODE;
                end
                `CCR_OFS_SRC: begin
                    s_next.src = AVS_WRITEDATA[7:0];
                end
                `CCR_OFS_DST: begin
                    s_next.dst = AVS_WRITEDATA[7:0];
                end
                `CCR_OFS_GIN1: begin
                    s_next.gin1 = AVS_WRITEDATA[7:0];
                end
                `CCR_OFS_GIN2: begin
                    s_next.gin2 = AVS_WRITEDATA[7:0];
                end
                `CCR_OFS_MASK: begin
                    s_next.mask = AVS_WRITEDATA[1:0];
                end
                default: begin
                end
            endcase
        end

        case (s_reg.phase)
            ccr_pkg::CCR_IDLE: begin
                s_next.rb = 1'b0;
            end
            ccr_pkg::CCR_DECODE: begin
                s_next.phase = ccr_pkg::CCR_STORE;
                s_next.rb = 1'b0;
                if (s_reg.cmd_first) begin
                    case (code)
                        `CCR_C1_IOSEL: begin
                            s_next.master = param[0];
                            s_next.clk_sel = param;
                            s_next.pll_ref = s_reg.gin1[3:0];
                            s_next.phase_align = s_reg.gin1[4];
                        end
                        `CCR_C1_RATE: begin
                            if (param[2]) begin
                                s_next.in_rate[src_line] = param[1:0];
                            end
                            if (param[3]) begin
                                s_next.out_rate[dst_line] = param[1:0];
                            end
                        end
                        `CCR_C1_SHIFT: begin
                            // 0 one input line, 1 all inputs, 2 all outputs, 3 both
                            for (int i = 0; i < 16; i++) begin
                                if ((param[1:0] == 2'h0 && i == int'(src_line))
                                    || param[1:0] == 2'h1 || param[1:0] == 2'h3) begin
                                    s_next.in_shift[i] = s_reg.gin1;
                                end
                            end
                            if (param[1]) begin
                                s_next.out_shift = s_reg.gin1;
                            end
                        end
                        default: begin
                        end
                    endcase
                end else begin
                    case (code)
                        `CCR_C2_FREQ: begin
                            if (param == 4'h0 || param == 4'h1) begin
                                s_next.osc16 = param[0];
                            end
                        end
                        `CCR_C2_PAR: begin
                            if (param[3:1] == 3'h0) begin
                                s_next.parallel = param[0];
                            end
                        end
                        `CCR_C2_IRQ: begin
                            if (param[1:0] != 2'h3 && param[3] == 1'b0) begin
                                s_next.irq_cfg = param;
                            end
                        end
                        `CCR_C2_STBY: begin
                            if (param[3:1] == 3'h0) begin
                                s_next.standby = param[0];
                            end
                        end
                        `CCR_C2_LOOP: begin
                            if (param[3:1] == 3'h0) begin
                                s_next.loop = param[0];
                            end
                        end
                        `CCR_C2_FRAME: begin
                            s_next.gp_clock[gp_line] = 1'b0;
                            s_next.gp_low[gp_line] = param[3];
                            s_next.gp_a[gp_line] = s_reg.gin1;
                            s_next.gp_b[gp_line] = s_reg.gin2;
                        end
                        `CCR_C2_CLOCK: begin
                            if (!param[3]) begin
                                s_next.gp_clock[gp_line] = 1'b1;
                                s_next.gp_a[gp_line] = s_reg.gin1;
                            end
                        end
                        `CCR_C2_RANGE: begin
                            if (param != 4'h7 && param < 4'hb) begin
                                s_next.range = param;
                            end
                        end
                        `CCR_C2_RDCFG: begin
                            s_next.rb = 1'b1;
                            // a later readback overwrites an uncollected result
                            case (param)
                                4'h0: begin
                                    s_next.result = {7'h0, s_reg.master};
                                end
                                4'h1: begin
                                    s_next.result = {4'h0, s_reg.pll_ref};
                                end
                                4'h5: begin
                                    s_next.result = {4'h0, s_reg.clk_sel};
                                end
                                4'h9: begin
                                    s_next.result = {7'h0, s_reg.phase_align};
                                end
                                4'ha: begin
                                    s_next.result = {7'h0, s_reg.osc16};
                                end
                                4'hb: begin
                                    s_next.result = {7'h0, s_reg.parallel};
                                end
                                4'hc: begin
                                    s_next.result = {4'h0, s_reg.irq_cfg};
                                end
                                4'hd: begin
                                    s_next.result = {7'h0, s_reg.standby};
                                end
                                4'he: begin
                                    s_next.result = {7'h0, s_reg.loop};
                                end
                                4'hf: begin
                                    s_next.result = {4'h0, s_reg.range};
                                end
                                default: begin
                                    s_next.result = 8'h00;
                                end
                            endcase
                        end
                        `CCR_C2_RDCLK: begin
                            if (!param[3]) begin
                                s_next.rb = 1'b1;
                                s_next.result = s_reg.gp_a[gp_line];
                                s_next.clkrb = {s_reg.gp_clock[gp_line],
                                    s_reg.gp_low[gp_line], s_reg.gp_b[gp_line]};
                            end
                        end
                        `CCR_C2_RDLINE: begin
                            if (param[3:1] == 3'h0) begin
                                s_next.rb = 1'b1;
                                s_next.result = param[0]
                                    ? {6'h0, s_reg.out_rate[dst_line]}
                                    : {6'h0, s_reg.in_rate[src_line]};
                            end
                        end
                        `CCR_C2_RDSHIFT: begin
                            if (param[3:1] == 3'h0) begin
                                s_next.rb = 1'b1;
                                s_next.result = param[0] ? s_reg.out_shift
                                    : s_reg.in_shift[src_line];
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ccr_pkg::CCR_STORE: begin
                s_next.phase = ccr_pkg::CCR_IDLE;
            end
            default: begin
                s_next.phase = ccr_pkg::CCR_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign AVS_WAITREQUEST = req && !s_reg.ack;
    assign AVS_READDATA = s_reg.rdata;
    // clock readback sets the result status bit, so it interrupts when that bit is unmasked
    assign IRQ = |(s_reg.status & s_reg.mask);
    assign PCM_LINE_OE = s_reg.standby;
    assign LOCAL_LOOP = s_reg.loop;
    assign PCM_CLOCK_MASTER = s_reg.master;
    assign OSC_16M_SEL = s_reg.osc16;
    assign PARALLEL_MODE = s_reg.parallel;
    assign PLL_LOCKED = pll_locked;
    assign DATA_RATE_RANGE = s_reg.range;
    assign PROG_CLK_CLOCK_MODE = s_reg.gp_clock;
    assign PROG_CLK_ACTIVE_LOW = s_reg.gp_low;
endmodule : ccr_top
